// *** design/cim_pkg.sv ***
// Purpose: Constants for the charger interrupt mask bank.
// Assumes: Single 25 MHz clock, synchronous active-low reset.
// Notes: Summary of operation follows.
package cim_pkg;
  localparam logic [7:0] CIM_OFS_CHG_MASK3 = 8'h2B;
  localparam logic [7:0] CIM_OFS_FLT_MASK0 = 8'h2C;
  localparam logic [7:0] CIM_OFS_FLT_MASK1 = 8'h2D;
  localparam logic [7:0] CIM_RST_VAL       = 8'h00;
  // Writable bit sets; everything else is reserved
  localparam logic [7:0] CIM_VLD_CHG_MASK3 = 8'h1F;
  localparam logic [7:0] CIM_VLD_FLT_MASK0 = 8'hFF;
  localparam logic [7:0] CIM_VLD_FLT_MASK1 = 8'hF4;
  // Bits of charger mask three that the watchdog clears
  localparam logic [7:0] CIM_WD_CLR_CHG3   = 8'h1F;
  localparam int         CIM_NUM_SRC       = 18;
  // Event index: [4:0] chg3 bits 4..0, [12:5] flt0, [17:13] flt1 7,6,5,4,2
  localparam int         CIM_IDX_FLT0      = 5;
  localparam int         CIM_IDX_FLT1      = 13;
  // Sources that fire on both edges: thermistor crossings, current regulation
  localparam logic [17:0] CIM_EDGE_BOTH    = 18'h0_100F;
  localparam int CIM_CLK_PERIOD_NS         = 40;
  localparam int CIM_IRQ_PULSE_NS          = 1000;
  localparam int CIM_IRQ_PULSE_CYC =
    (CIM_IRQ_PULSE_NS + CIM_CLK_PERIOD_NS - 1) / CIM_CLK_PERIOD_NS;
endpackage

// *** design/cim_edge_sync.sv ***
// Purpose: Synchronise event levels and turn edges into one-cycle pulses.
// Assumes: Event levels come from analog detectors, asynchronous to clock.
// Notes: Output pulse is registered, three cycles after the level moves.
`timescale 1ns/100ps
module cim_edge_sync
  import cim_pkg::*;
#(
  parameter int          N         = CIM_NUM_SRC,
  parameter logic [N-1:0] EDGE_BOTH = CIM_EDGE_BOTH
) (
  input  wire logic         ref_clk,  // 25 MHz clock
  input  wire logic         rst_n,    // Synchronous reset, active low
  input  wire logic [N-1:0] ev_lvl,   // Raw event levels
  output logic      [N-1:0] ev_pulse  // One-cycle detected edges
);
  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] pulse;
  } cim_sync_t;

  cim_sync_t st_ff;
  cim_sync_t nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = ev_lvl;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    // Rising edge, or any change for both-edge sources (thermistor crossings, current regulation)
    nxt_st.pulse = (st_ff.s2 & ~st_ff.s3) |
                   (EDGE_BOTH & ~st_ff.s2 & st_ff.s3);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ev_pulse = st_ff.pulse;
endmodule

// *** design/cim_mask_bank.sv ***
// Purpose: Three interrupt mask registers gating charger events onto INT.
// Assumes: Register port is driven by the serial slave on the same clock.
// Notes: A host write loses to register reset, or for charger mask three to watchdog, in one cycle.
`timescale 1ns/100ps
module cim_mask_bank
  import cim_pkg::*;
#(
  parameter int PULSE_CYC = CIM_IRQ_PULSE_CYC
) (
  input  wire logic       ref_clk,                      // 25 MHz clock
  input  wire logic       rst_n,                        // Sync reset, low
  input  wire logic [7:0] reg_addr,                     // Register offset
  input  wire logic       reg_wr_en,                    // Write strobe
  input  wire logic [7:0] reg_wr_data,                  // Write data
  input  wire logic       reg_rd_en,                    // Read strobe
  input  wire logic       reg_soft_reset,               // Register reset
  input  wire logic       watchdog_expired,             // Watchdog pulse
  input  wire logic       battery_low_for_otg_evt,      // VBAT below OTG
  input  wire logic       therm_cold_evt,               // Past cold point
  input  wire logic       therm_cool_evt,               // Past cool point
  input  wire logic       therm_warm_evt,               // Past warm point
  input  wire logic       therm_hot_evt,                // Past hot point
  input  wire logic       battery_current_regulation_evt, // In current reg
  input  wire logic       input_bus_overvoltage_evt,    // Bus OVP
  input  wire logic       battery_overvoltage_evt,      // Battery OVP
  input  wire logic       input_bus_overcurrent_evt,    // Bus OCP
  input  wire logic       battery_overcurrent_evt,      // Battery OCP
  input  wire logic       converter_overcurrent_evt,    // Converter OCP
  input  wire logic       source_two_overvoltage_evt,   // Source two OVP
  input  wire logic       source_one_overvoltage_evt,   // Source one OVP
  input  wire logic       system_rail_short_evt,        // System short
  input  wire logic       system_rail_overvoltage_evt,  // System OVP
  input  wire logic       otg_output_overvoltage_evt,   // OTG OVP
  input  wire logic       otg_output_undervoltage_evt,  // OTG UVP
  input  wire logic       die_thermal_shutdown_evt,     // Die shutdown
  output logic [7:0]      reg_rd_data,                  // Read data
  output logic [17:0]     event_flag_pulse,             // Detected events, before masking
  output logic            host_irq_n                    // INT, active low
);
  localparam int CNT_W = $clog2(PULSE_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(PULSE_CYC);

  typedef enum logic [1:0] {
    CIM_IDLE  = 2'b01,
    CIM_PULSE = 2'b10
  } cim_irq_st_t;

  typedef struct packed {
    logic [7:0]       chg3;
    logic [7:0]       flt0;
    logic [7:0]       flt1;
    logic [7:0]       rd_data;
    logic [17:0]      flag;
    cim_irq_st_t      irq_st;
    logic [CNT_W-1:0] cnt;
    logic             irq_n;
  } cim_state_t;

  cim_state_t st_ff;
  cim_state_t nxt_st;
  logic [17:0] ev_lvl;
  logic [17:0] ev_pulse;
  logic [17:0] src_mask;
  logic        trig;

  // Mask for every source, in event-index order
  function automatic logic [17:0] mask_vec(input logic [7:0] c3,
                                           input logic [7:0] f0,
                                           input logic [7:0] f1);
    mask_vec = {f1[7:4], f1[2], f0, c3[4:0]};
  endfunction

  // Register read view with reserved bits forced low
  function automatic logic [7:0] rd_view(input logic [7:0] addr,
                                         input cim_state_t s);
    unique case (addr)
      CIM_OFS_CHG_MASK3: rd_view = s.chg3 & CIM_VLD_CHG_MASK3;
      CIM_OFS_FLT_MASK0: rd_view = s.flt0 & CIM_VLD_FLT_MASK0;
      CIM_OFS_FLT_MASK1: rd_view = s.flt1 & CIM_VLD_FLT_MASK1;
      default:           rd_view = 8'h00;
    endcase
  endfunction

  assign ev_lvl = {system_rail_short_evt, system_rail_overvoltage_evt,
                   otg_output_overvoltage_evt, otg_output_undervoltage_evt,
                   die_thermal_shutdown_evt,
                   battery_current_regulation_evt, input_bus_overvoltage_evt,
                   battery_overvoltage_evt, input_bus_overcurrent_evt,
                   battery_overcurrent_evt, converter_overcurrent_evt,
                   source_two_overvoltage_evt, source_one_overvoltage_evt,
                   battery_low_for_otg_evt, therm_cold_evt, therm_cool_evt,
                   therm_warm_evt, therm_hot_evt};

  cim_edge_sync #(
    .N         (CIM_NUM_SRC),
    .EDGE_BOTH (CIM_EDGE_BOTH)
  ) u_edge (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .ev_lvl   (ev_lvl),
    .ev_pulse (ev_pulse)
  );

  assign src_mask = mask_vec(st_ff.chg3, st_ff.flt0, st_ff.flt1);
  // Mask bit 1 blocks the source; 0 lets it through
  assign trig = |(ev_pulse & ~src_mask);

  always_comb begin
    nxt_st = st_ff;
    // Detection is reported whatever the masks say
    nxt_st.flag = ev_pulse;
    if (reg_rd_en) begin
      nxt_st.rd_data = rd_view(reg_addr, st_ff);
    end
    if (reg_wr_en) begin
      unique case (reg_addr)
        CIM_OFS_CHG_MASK3:
          nxt_st.chg3 = reg_wr_data & CIM_VLD_CHG_MASK3;
        CIM_OFS_FLT_MASK0:
          nxt_st.flt0 = reg_wr_data & CIM_VLD_FLT_MASK0;
        CIM_OFS_FLT_MASK1:
          nxt_st.flt1 = reg_wr_data & CIM_VLD_FLT_MASK1;
        default: ;
      endcase
    end
    // Only the temperature group and OTG-low bit follow the watchdog
    if (watchdog_expired) begin
      nxt_st.chg3 = st_ff.chg3 & ~CIM_WD_CLR_CHG3;
    end
    if (reg_soft_reset) begin
      nxt_st.chg3 = CIM_RST_VAL;
      nxt_st.flt0 = CIM_RST_VAL;
      nxt_st.flt1 = CIM_RST_VAL;
    end
    // Retrigger restarts the pulse so back-to-back events are not merged
    // into silence; the host sees one stretched low period instead.
    unique case (st_ff.irq_st)
      CIM_IDLE: begin
        if (trig) begin
          nxt_st.irq_st = CIM_PULSE;
          nxt_st.cnt    = CNT_LOAD;
          nxt_st.irq_n  = 1'b0;
        end
      end
      CIM_PULSE: begin
        if (trig) begin
          nxt_st.cnt = CNT_LOAD;
        end else if (st_ff.cnt <= CNT_W'(1)) begin
          nxt_st.irq_st = CIM_IDLE;
          nxt_st.cnt    = '0;
          nxt_st.irq_n  = 1'b1;
        end else begin
          nxt_st.cnt = st_ff.cnt - CNT_W'(1);
        end
      end
      default: begin
        nxt_st.irq_st = CIM_IDLE;
        nxt_st.cnt    = '0;
        nxt_st.irq_n  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_ff        <= '0;
      st_ff.irq_st <= CIM_IDLE;
      st_ff.irq_n  <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rd_data      = st_ff.rd_data;
  assign event_flag_pulse = st_ff.flag;
  assign host_irq_n       = st_ff.irq_n;

  property p_unmasked_fires;
    @(posedge ref_clk) disable iff (!rst_n)
      trig |=> !host_irq_n;
  endproperty
  a_unmasked_fires: assert property (p_unmasked_fires)
    else $error("Unmasked event did not assert the interrupt");

  property p_masked_quiet;
    @(posedge ref_clk) disable iff (!rst_n)
      (host_irq_n && !trig) |=> host_irq_n;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("Interrupt asserted with no unmasked event");

  property p_chg3_gate;
    @(posedge ref_clk) disable iff (!rst_n)
      (host_irq_n && (ev_pulse[4:0] != 5'h00) &&
       ((ev_pulse[4:0] & ~st_ff.chg3[4:0]) == 5'h00) &&
       ((ev_pulse[17:5] & ~src_mask[17:5]) == 13'h0000))
      |=> host_irq_n;
  endproperty
  a_chg3_gate: assert property (p_chg3_gate)
    else $error("Masked thermistor or OTG-low event raised interrupt");

  property p_pulse_len;
    @(posedge ref_clk) disable iff (!rst_n)
      $fell(host_irq_n) |-> !host_irq_n [*8];
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("Interrupt pulse shorter than its minimum");

  property p_pulse_ends;
    @(posedge ref_clk) disable iff (!rst_n)
      (!host_irq_n && !trig) [*2] |-> ##[0:30] host_irq_n;
  endproperty
  a_pulse_ends: assert property (p_pulse_ends)
    else $error("Interrupt pulse never released");

  property p_wd_clear;
    @(posedge ref_clk) disable iff (!rst_n)
      watchdog_expired |=> (st_ff.chg3 == 8'h00) &&
        (($stable(st_ff.flt0) && $stable(st_ff.flt1)) ||
         $past(reg_wr_en) || $past(reg_soft_reset));
  endproperty
  a_wd_clear: assert property (p_wd_clear)
    else $error("Watchdog did not clear charger mask three alone");

  property p_soft_reset;
    @(posedge ref_clk) disable iff (!rst_n)
      reg_soft_reset |=> ({st_ff.chg3, st_ff.flt0, st_ff.flt1} == 24'h00_0000);
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("Register reset left a mask bit set");

  property p_reserved_zero;
    @(posedge ref_clk) disable iff (!rst_n)
      reg_rd_en |=> ((reg_rd_data & ~CIM_VLD_FLT_MASK1) == 8'h00) ||
                    ($past(reg_addr) != CIM_OFS_FLT_MASK1);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved bit read back as one");

  property p_flag_free;
    @(posedge ref_clk) disable iff (!rst_n)
      (ev_pulse != 18'h0_0000) |=> (event_flag_pulse == $past(ev_pulse));
  endproperty
  a_flag_free: assert property (p_flag_free)
    else $error("Event flag lost while masked");

  property p_reserved_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      ((st_ff.chg3 & ~CIM_VLD_CHG_MASK3) == 8'h00) &&
      ((st_ff.flt1 & ~CIM_VLD_FLT_MASK1) == 8'h00);
  endproperty
  a_reserved_hold: assert property (p_reserved_hold)
    else $error("Reserved mask bit stored as one");

  property p_wr_chg3;
    @(posedge ref_clk) disable iff (!rst_n)
      (reg_wr_en && (reg_addr == CIM_OFS_CHG_MASK3) &&
       !watchdog_expired && !reg_soft_reset) |=>
        (st_ff.chg3 == ($past(reg_wr_data) & CIM_VLD_CHG_MASK3));
  endproperty
  a_wr_chg3: assert property (p_wr_chg3)
    else $error("Write to charger mask three did not land");

  property p_wr_flt0;
    @(posedge ref_clk) disable iff (!rst_n)
      (reg_wr_en && (reg_addr == CIM_OFS_FLT_MASK0) &&
       !reg_soft_reset) |=>
        (st_ff.flt0 == ($past(reg_wr_data) & CIM_VLD_FLT_MASK0));
  endproperty
  a_wr_flt0: assert property (p_wr_flt0)
    else $error("Write to fault mask zero did not land");

  property p_wr_flt1;
    @(posedge ref_clk) disable iff (!rst_n)
      (reg_wr_en && (reg_addr == CIM_OFS_FLT_MASK1) &&
       !reg_soft_reset) |=>
        (st_ff.flt1 == ($past(reg_wr_data) & CIM_VLD_FLT_MASK1));
  endproperty
  a_wr_flt1: assert property (p_wr_flt1)
    else $error("Write to fault mask one did not land");

  property p_cnt_bound;
    @(posedge ref_clk) disable iff (!rst_n)
      (st_ff.cnt <= CNT_LOAD) &&
      (host_irq_n == (st_ff.irq_st == CIM_IDLE));
  endproperty
  a_cnt_bound: assert property (p_cnt_bound)
    else $error("Pulse counter or state out of step");

  property p_retrigger;
    @(posedge ref_clk) disable iff (!rst_n)
      (!host_irq_n && trig) |=> !host_irq_n && (st_ff.cnt == CNT_LOAD);
  endproperty
  a_retrigger: assert property (p_retrigger)
    else $error("Retrigger did not restart the pulse");

  property p_unmapped_zero;
    @(posedge ref_clk) disable iff (!rst_n)
      (reg_rd_en && (reg_addr != CIM_OFS_CHG_MASK3) &&
       (reg_addr != CIM_OFS_FLT_MASK0) &&
       (reg_addr != CIM_OFS_FLT_MASK1)) |=> (reg_rd_data == 8'h00);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("Unmapped offset read back nonzero");

  property p_rd_flt0;
    @(posedge ref_clk) disable iff (!rst_n)
      (reg_rd_en && (reg_addr == CIM_OFS_FLT_MASK0)) |=>
        (reg_rd_data == $past(st_ff.flt0));
  endproperty
  a_rd_flt0: assert property (p_rd_flt0)
    else $error("Fault mask zero read returned wrong value");

  property p_rd_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      !reg_rd_en |=> $stable(reg_rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("Read data changed without a read");
endmodule

// *** verif/cim_host_model.sv ***
// Purpose: Host side of the register port, in place of the serial master.
// Assumes: One strobe per access, driven just after the rising edge.
// Notes: Idle address and data show the inverse of the last value.
`timescale 1ns/100ps
module cim_host_model (
  input  wire logic       ref_clk,     // 25 MHz clock
  output logic      [7:0] reg_addr,    // Register offset
  output logic            reg_wr_en,   // Write strobe
  output logic      [7:0] reg_wr_data, // Write data
  output logic            reg_rd_en,   // Read strobe
  input  wire logic [7:0] reg_rd_data  // Read data
);
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr_en = 1'b0;
    reg_addr = ~a;
    reg_wr_data = ~d;
  endtask

  // Data is registered on the taking edge, so it is settled here
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    d = reg_rd_data;
  endtask
endmodule

// *** verif/tb_top.sv ***
// Purpose: Self-checking bench for the charger interrupt mask bank.
// Assumes: Host model drives the register port; bench drives events.
// Notes: Pulse width shortened so each event case stays brief.
`timescale 1ns/100ps
module tb_top;
  import cim_pkg::*;
  localparam int PW = 10;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        reg_soft_reset = 1'b0;
  logic        watchdog_expired = 1'b0;
  logic [17:0] ev = 18'h0_0000;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wr_data;
  logic [7:0]  reg_rd_data;
  logic [7:0]  rd;
  logic        reg_wr_en;
  logic        reg_rd_en;
  logic        host_irq_n;
  logic [17:0] event_flag_pulse;
  logic [17:0] seen;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cyc = 0;

  always #20 ref_clk = ~ref_clk;

  cim_host_model cim_host_model_i (.ref_clk(ref_clk), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data));

  cim_mask_bank #(.PULSE_CYC(PW)) cim_mask_bank_i (.ref_clk(ref_clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
    .reg_soft_reset(reg_soft_reset), .watchdog_expired(watchdog_expired),
    .battery_low_for_otg_evt(ev[4]), .therm_cold_evt(ev[3]),
    .therm_cool_evt(ev[2]), .therm_warm_evt(ev[1]), .therm_hot_evt(ev[0]),
    .battery_current_regulation_evt(ev[12]),
    .input_bus_overvoltage_evt(ev[11]), .battery_overvoltage_evt(ev[10]),
    .input_bus_overcurrent_evt(ev[9]), .battery_overcurrent_evt(ev[8]),
    .converter_overcurrent_evt(ev[7]), .source_two_overvoltage_evt(ev[6]),
    .source_one_overvoltage_evt(ev[5]), .system_rail_short_evt(ev[17]),
    .system_rail_overvoltage_evt(ev[16]),
    .otg_output_overvoltage_evt(ev[15]),
    .otg_output_undervoltage_evt(ev[14]),
    .die_thermal_shutdown_evt(ev[13]), .reg_rd_data(reg_rd_data),
    .event_flag_pulse(event_flag_pulse), .host_irq_n(host_irq_n));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp(string what, logic [17:0] exp, logic [17:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdc(logic [7:0] a, logic [7:0] exp);
    cim_host_model_i.rd(a, rd);
    cmp("reg_rd_data", {10'h000, exp}, {10'h000, rd});
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge ref_clk);
    #1;
    s = 1'b0;
  endtask

  // Bounded wait for a flag pulse; seen stays zero if none comes
  task automatic wait_flag();
    seen = 18'h0_0000;
    for (int k = 0; k < 8 && seen === 18'h0_0000; k++) begin
      @(posedge ref_clk);
      #1;
      seen = event_flag_pulse;
    end
  endtask

  task automatic ev_test(int i, logic m);
    logic [7:0] ofs;
    int         b;
    ofs = i < 5 ? CIM_OFS_CHG_MASK3 :
          i < 13 ? CIM_OFS_FLT_MASK0 : CIM_OFS_FLT_MASK1;
    b = i < 5 ? i : i < 13 ? i - 5 : i == 13 ? 2 : i - 10;
    cim_host_model_i.wr(ofs, m ? 8'h01 << b : 8'h00);
    ev[i] = 1'b1;
    wait_flag();
    cmp("event_flag_pulse", 18'h0_0001 << i, seen);
    @(posedge ref_clk);
    #1;
    cmp("host_irq_n", {17'h0_0000, m}, {17'h0_0000, host_irq_n});
    repeat (PW - 2) @(posedge ref_clk);
    #1;
    cmp("host_irq_n", {17'h0_0000, m}, {17'h0_0000, host_irq_n});
    @(posedge ref_clk);
    #1;
    cmp("host_irq_n", 18'h0_0001, {17'h0_0000, host_irq_n});
    ev[i] = 1'b0;
    wait_flag();
    // Thermistor crossings and current regulation report both edges
    cmp("event_flag_pulse", (i < 4 || i == 12) ? 18'h0_0001 << i
        : 18'h0_0000, seen);
    @(posedge ref_clk);
    #1;
    cmp("host_irq_n", {17'h0_0000, m || !(i < 4 || i == 12)},
        {17'h0_0000, host_irq_n});
    repeat (PW + 4) @(posedge ref_clk);
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    rdc(CIM_OFS_CHG_MASK3, 8'h00);
    rdc(CIM_OFS_FLT_MASK0, 8'h00);
    rdc(CIM_OFS_FLT_MASK1, 8'h00);
    $display("test reset_values done");
    for (int a = 8'h2B; a <= 8'h2E; a++)
      cim_host_model_i.wr(a[7:0], 8'hFF);
    rdc(CIM_OFS_CHG_MASK3, 8'h1F);
    rdc(CIM_OFS_FLT_MASK0, 8'hFF);
    rdc(CIM_OFS_FLT_MASK1, 8'hF4);
    rdc(8'h2E, 8'h00);
    $display("test write_readback done");
    pulse(watchdog_expired);
    rdc(CIM_OFS_CHG_MASK3, 8'h00);
    rdc(CIM_OFS_FLT_MASK0, 8'hFF);
    rdc(CIM_OFS_FLT_MASK1, 8'hF4);
    $display("test watchdog_clear done");
    cim_host_model_i.wr(CIM_OFS_CHG_MASK3, 8'hFF);
    pulse(reg_soft_reset);
    rdc(CIM_OFS_CHG_MASK3, 8'h00);
    rdc(CIM_OFS_FLT_MASK0, 8'h00);
    rdc(CIM_OFS_FLT_MASK1, 8'h00);
    $display("test register_reset done");
    for (int i = 0; i < 18; i++) begin
      ev_test(i, 1'b1);
      ev_test(i, 1'b0);
    end
    $display("test event_masking done");
    // Second unmasked event inside the pulse must stretch it
    ev[5] = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    ev[6] = 1'b1;
    repeat (PW + 3) @(posedge ref_clk);
    #1;
    cmp("host_irq_n", 18'h0_0000, {17'h0_0000, host_irq_n});
    repeat (4) @(posedge ref_clk);
    #1;
    cmp("host_irq_n", 18'h0_0001, {17'h0_0000, host_irq_n});
    ev[6:5] = 2'b00;
    repeat (12) @(posedge ref_clk);
    $display("test retrigger done");
    tally_and_finish();
  end
endmodule
